// File: bench/dual_uart_host_bus_port_bench.sv
`timescale 1ns/1ps
module dual_uart_host_bus_port_bench
  import host_port_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic cs_n, channel_select, read_strobe_n, write_strobe_n, host_oe, data_oe;
  logic [2:0] addr, reg_addr;
  logic [7:0] bus, host_d, data_out, wr_data, rd_data_a, rd_data_b, pat = 8'h5a;
  logic rd_a, rd_b, wr_a, wr_b, irq_channel_a, irq_channel_b;
  logic tx_ready_a_n, tx_ready_b_n, serial_out_a, serial_out_b;
  logic [7:0] alternate_function_reg = 8'h00;
  logic [7:0] modem_control_reg_a = 8'h00, modem_control_reg_b = 8'h00;
  logic irq_req_a = 1'b1, irq_req_b = 1'b1, tx_space_a = 1'b1, tx_space_b = 1'b1;
  logic tx_active_a = 1'b0, tx_active_b = 1'b0, tx_bit_a = 1'b0, tx_bit_b = 1'b0;
  logic [7:0] n_rd_a = 0, n_rd_b = 0, n_wr_a = 0, n_wr_b = 0, last_wd, q;
  logic [2:0] last_wa;
  logic oe_bad = 1'b0;
  int miscompares = 0;
  int tests_run = 0;

  always #4 ref_clk = ~ref_clk;
  // A released bus shows a pattern that changes every cycle.
  always @(posedge ref_clk) pat <= ~pat;
  assign bus = host_oe ? host_d : (data_oe ? data_out : pat);
  // The channels answer with a byte made of their own code and the address.
  assign rd_data_a = {5'h14, reg_addr};
  assign rd_data_b = {5'h0b, reg_addr};

  dual_uart_host_bus_port dut (.ref_clk, .reset, .cs_n, .channel_select, .addr,
    .read_strobe_n, .write_strobe_n, .data_in(bus), .data_out, .data_oe, .reg_addr,
    .rd_a, .rd_b, .rd_data_a, .rd_data_b, .wr_a, .wr_b, .wr_data, .alternate_function_reg,
    .modem_control_reg_a, .modem_control_reg_b, .irq_req_a, .irq_req_b, .tx_space_a,
    .tx_space_b, .tx_active_a, .tx_active_b, .tx_bit_a, .tx_bit_b, .irq_channel_a,
    .irq_channel_b, .tx_ready_a_n, .tx_ready_b_n, .serial_out_a, .serial_out_b);
  host_model host (.ref_clk, .bus, .cs_n, .channel_select, .addr, .read_strobe_n,
    .write_strobe_n, .host_d, .host_oe);

  // Counts channel requests and flags any bus drive outside a selected read.
  // Counting waits for reset, so the unknown pulses before the first edge are never added.
  always @(posedge ref_clk) begin
    if (!reset) begin
      n_rd_a <= n_rd_a + rd_a;
      n_rd_b <= n_rd_b + rd_b;
      n_wr_a <= n_wr_a + wr_a;
      n_wr_b <= n_wr_b + wr_b;
      if (wr_a | wr_b) begin
        last_wd <= wr_data;
        last_wa <= reg_addr;
      end
      if (data_oe !== 1'b0 && (cs_n | read_strobe_n | host_oe)) oe_bad <= 1'b1;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Reset holds interrupts low, ready high and the transmit pins high.
  task automatic t_reset();
    chk({data_oe, irq_channel_a, irq_channel_b, tx_ready_a_n, tx_ready_b_n,
         serial_out_a, serial_out_b}, 8'h0f);
  endtask

  // Every address of both channels is read back with the channel's byte.
  task automatic t_read();
    for (int s = 0; s < 2; s++) begin
      for (int a = 0; a < 8; a++) begin
        host.cyc(1'b0, 1'b1, s[0], a[2:0], 8'h00, q);
        chk(q, {s[0] ? 5'h14 : 5'h0b, a[2:0]});
      end
    end
    chk(n_rd_a, 8'd8);
    chk(n_rd_b, 8'd8);
  endtask

  // Writes reach only the selected channel unless the broadcast bit is set.
  task automatic t_write();
    for (int s = 0; s < 2; s++) begin
      for (int a = 0; a < 8; a++) begin
        host.cyc(1'b0, 1'b0, s[0], a[2:0], {s[0], 4'h9, a[2:0]}, q);
        chk(last_wd, {s[0], 4'h9, a[2:0]});
        chk(last_wa, a[2:0]);
      end
    end
    chk(n_wr_a, 8'd8);
    chk(n_wr_b, 8'd8);
    alternate_function_reg <= 8'h01;
    host.cyc(1'b0, 1'b0, 1'b0, 3'h5, 8'hc3, q);
    chk(n_wr_a, 8'd9);
    chk(n_wr_b, 8'd9);
    chk(last_wd, 8'hc3);
    alternate_function_reg <= 8'h00;
  endtask

  // Strobes without chip select are ignored and the bus stays released.
  task automatic t_cs();
    host.cyc(1'b1, 1'b1, 1'b1, 3'h2, 8'h00, q);
    host.cyc(1'b1, 1'b0, 1'b0, 3'h2, 8'h77, q);
    chk(n_rd_a, 8'd8);
    chk(n_rd_b, 8'd8);
    chk(n_wr_a, 8'd9);
    chk(n_wr_b, 8'd9);
    chk(oe_bad, 1'b0);
  endtask

  // Channel status and serial mode combinations reach the pins.
  task automatic t_pins();
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      {tx_bit_a, tx_active_a, tx_space_a, irq_req_a} <= i[3:0];
      {irq_req_b, tx_space_b, tx_active_b, tx_bit_b} <= {~i[0], ~i[1], i[2], i[3]};
      modem_control_reg_a <= {1'b0, i[0], 6'h00};
      modem_control_reg_b <= {1'b0, ~i[0], 6'h00};
      repeat (3) @(posedge ref_clk);
      chk({irq_channel_a, irq_channel_b, tx_ready_a_n, tx_ready_b_n, serial_out_a,
           serial_out_b}, {i[0], ~i[0], ~i[1], i[1], i[2] ? i[3] : ~i[0],
           i[2] ? i[3] : i[0]});
    end
  endtask

  // Watchdog for a hung run.
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    t_reset();
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_read();
    t_write();
    t_cs();
    t_pins();
    print_verdict();
  end
endmodule

// File: bench/host_model.sv
`timescale 1ns/1ps
module host_model
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [DATA_W-1:0] bus,
  output logic cs_n,
  output logic channel_select,
  output logic [ADDR_W-1:0] addr,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [DATA_W-1:0] host_d,
  output logic host_oe
);
  // The host starts with strobes high and the bus released.
  initial begin
    cs_n = 1'b1;
    channel_select = 1'b0;
    addr = 3'h0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_d = 8'h00;
    host_oe = 1'b0;
  end

  // One bus cycle with the strobe low for four cycles and three idle cycles after.
  task automatic cyc(input logic c_n, input logic is_rd, input logic sel,
                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] q);
    @(posedge ref_clk);
    cs_n <= c_n;
    channel_select <= sel;
    addr <= a;
    read_strobe_n <= ~is_rd;
    write_strobe_n <= is_rd;
    host_d <= d;
    host_oe <= ~is_rd;
    repeat (4) @(posedge ref_clk);
    q = bus;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    host_oe <= 1'b0;
    cs_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
endmodule

// File: hw/chan_pin_stage.sv
`timescale 1ns/1ps
module chan_pin_stage
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  chan_status_if.stage st,
  output logic irq_out,
  output logic tx_ready_n,
  output logic serial_out
);
  logic irq_ff, nxt_irq;
  logic rdy_n_ff, nxt_rdy_n;
  logic sout_ff, nxt_sout;

  // Next values of the channel's pins; the idle level depends on the coding mode.
  always_comb begin
    nxt_irq = st.irq_req;
    nxt_rdy_n = ~st.tx_space;
    if (reset) begin
      nxt_irq = 1'b0;
      nxt_rdy_n = 1'b1;
      nxt_sout = STD_IDLE_LVL;
    end else if (st.ir_en) begin
      nxt_sout = st.tx_active ? st.tx_bit : IR_IDLE_LVL;
    end else begin
      nxt_sout = st.tx_active ? st.tx_bit : STD_IDLE_LVL;
    end
  end

  // Pin registers.
  always_ff @(posedge ref_clk) begin
    irq_ff <= nxt_irq;
    rdy_n_ff <= nxt_rdy_n;
    sout_ff <= nxt_sout;
  end

  assign irq_out = irq_ff;
  assign tx_ready_n = rdy_n_ff;
  assign serial_out = sout_ff;

  irq_follow_a: assert property (@(posedge ref_clk) disable iff (reset)
    st.irq_req |=> irq_out) else $error("interrupt did not follow request");
  ready_level_a: assert property (@(posedge ref_clk) disable iff (reset)
    st.tx_space |=> !tx_ready_n) else $error("ready not low with space");
  std_idle_a: assert property (@(posedge ref_clk)
    (reset || (!st.ir_en && !st.tx_active)) |=> serial_out) else $error("std idle not high");
  ir_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
    (st.ir_en && !st.tx_active) |=> !serial_out) else $error("ir idle not low");
endmodule

// File: hw/chan_status_if.sv
`timescale 1ns/1ps
interface chan_status_if;
  logic irq_req;
  logic tx_space;
  logic tx_active;
  logic tx_bit;
  logic ir_en;
  modport src (output irq_req, output tx_space, output tx_active, output tx_bit, output ir_en);
  modport stage (input irq_req, input tx_space, input tx_active, input tx_bit, input ir_en);
endinterface

// File: hw/dual_uart_host_bus_port.sv
`timescale 1ns/1ps
// Function
// - A falling read strobe starts a read of the register that the address picks.
// - During a read the fetched byte is driven on the bus for the host to take at the rise.
// - A write's byte is stored into the addressed register when the write strobe rises.
// - Falling strobes and channel select count only while chip select is low; a rising strobe ends the cycle whatever chip select.
// - Channel select low picks channel B and high picks channel A.
// - With the broadcast bit set a write goes to both channels whatever the select.
// - Each channel has an active high interrupt output raised while it needs service.
// - Each channel has an active low transmitter ready output showing its transmit space.
// - In standard mode the transmit pin is high in reset and when idle.
// - In infrared mode the transmit pin carries coded data and rests low when idle.
// - The three address lines choose one of eight registers of the chosen channel.
// - Data passes on an eight bit two way bus, host driving writes and device reads.
module dual_uart_host_bus_port
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic channel_select,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic [ADDR_W-1:0] reg_addr,
  output logic rd_a,
  output logic rd_b,
  input wire logic [DATA_W-1:0] rd_data_a,
  input wire logic [DATA_W-1:0] rd_data_b,
  output logic wr_a,
  output logic wr_b,
  output logic [DATA_W-1:0] wr_data,
  input wire logic [DATA_W-1:0] alternate_function_reg,
  input wire logic [DATA_W-1:0] modem_control_reg_a,
  input wire logic [DATA_W-1:0] modem_control_reg_b,
  input wire logic irq_req_a,
  input wire logic irq_req_b,
  input wire logic tx_space_a,
  input wire logic tx_space_b,
  input wire logic tx_active_a,
  input wire logic tx_active_b,
  input wire logic tx_bit_a,
  input wire logic tx_bit_b,
  output logic irq_channel_a,
  output logic irq_channel_b,
  output logic tx_ready_a_n,
  output logic tx_ready_b_n,
  output logic serial_out_a,
  output logic serial_out_b
);
  port_state_t state_ff, nxt_state;
  logic rd_n_ff, nxt_rd_n;
  logic wr_n_ff, nxt_wr_n;
  logic sel_a_ff, nxt_sel_a;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] hold_ff, nxt_hold;
  logic [DATA_W-1:0] dout_ff, nxt_dout;
  logic rd_a_ff, nxt_rd_a;
  logic rd_b_ff, nxt_rd_b;
  logic wr_a_ff, nxt_wr_a;
  logic wr_b_ff, nxt_wr_b;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata;
  logic rd_fall, wr_fall, rd_rise, wr_rise, bcast;

  // Strobe edges seen against last cycle's levels.
  assign rd_fall = rd_n_ff & ~read_strobe_n;
  assign wr_fall = wr_n_ff & ~write_strobe_n;
  assign rd_rise = ~rd_n_ff & read_strobe_n;
  assign wr_rise = ~wr_n_ff & write_strobe_n;
  assign bcast = alternate_function_reg[BCAST_BIT];

  // Sequencing of read and write cycles and the one-cycle register strobes.
  always_comb begin
    nxt_state = state_ff;
    nxt_rd_n = read_strobe_n;
    nxt_wr_n = write_strobe_n;
    nxt_sel_a = sel_a_ff;
    nxt_addr = addr_ff;
    nxt_hold = hold_ff;
    nxt_dout = dout_ff;
    nxt_rd_a = 1'b0;
    nxt_rd_b = 1'b0;
    nxt_wr_a = 1'b0;
    nxt_wr_b = 1'b0;
    nxt_wdata = wdata_ff;
    case (state_ff)
      ST_IDLE: begin
        if (!cs_n && rd_fall) begin
          nxt_state = ST_READ;
          nxt_addr = addr;
          nxt_sel_a = channel_select;
          nxt_rd_a = channel_select;
          nxt_rd_b = ~channel_select;
        end else if (!cs_n && wr_fall) begin
          nxt_state = ST_WRITE;
          nxt_addr = addr;
          nxt_sel_a = channel_select;
          nxt_hold = data_in;
        end
      end
      ST_READ: begin
        // The channel answers in the cycle its read strobe is high.
        if (rd_a_ff || rd_b_ff) begin
          nxt_dout = sel_a_ff ? rd_data_a : rd_data_b;
        end
        if (rd_rise) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (wr_rise) begin
          nxt_state = ST_IDLE;
          nxt_wdata = hold_ff;
          nxt_wr_a = sel_a_ff | bcast;
          nxt_wr_b = ~sel_a_ff | bcast;
        end else begin
          nxt_hold = data_in;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (reset) begin
      nxt_state = ST_IDLE;
      nxt_rd_n = 1'b1;
      nxt_wr_n = 1'b1;
      nxt_sel_a = 1'b1;
      nxt_addr = '0;
      nxt_hold = '0;
      nxt_dout = RD_DATA_RST;
      nxt_rd_a = 1'b0;
      nxt_rd_b = 1'b0;
      nxt_wr_a = 1'b0;
      nxt_wr_b = 1'b0;
      nxt_wdata = '0;
    end
  end

  // Host port registers.
  always_ff @(posedge ref_clk) begin
    state_ff <= nxt_state;
    rd_n_ff <= nxt_rd_n;
    wr_n_ff <= nxt_wr_n;
    sel_a_ff <= nxt_sel_a;
    addr_ff <= nxt_addr;
    hold_ff <= nxt_hold;
    dout_ff <= nxt_dout;
    rd_a_ff <= nxt_rd_a;
    rd_b_ff <= nxt_rd_b;
    wr_a_ff <= nxt_wr_a;
    wr_b_ff <= nxt_wr_b;
    wdata_ff <= nxt_wdata;
  end

  // Bus drive only while selected and reading, and never inside a write cycle, so the host is
  // never fought.
  assign data_oe = ~cs_n & ~read_strobe_n & ~reset & (state_ff != ST_WRITE);
  assign data_out = dout_ff;
  assign reg_addr = addr_ff;
  assign rd_a = rd_a_ff;
  assign rd_b = rd_b_ff;
  assign wr_a = wr_a_ff;
  assign wr_b = wr_b_ff;
  assign wr_data = wdata_ff;

  chan_status_if st_a ();
  chan_status_if st_b ();
  assign st_a.irq_req = irq_req_a;
  assign st_a.tx_space = tx_space_a;
  assign st_a.tx_active = tx_active_a;
  assign st_a.tx_bit = tx_bit_a;
  assign st_a.ir_en = modem_control_reg_a[IR_EN_BIT];
  assign st_b.irq_req = irq_req_b;
  assign st_b.tx_space = tx_space_b;
  assign st_b.tx_active = tx_active_b;
  assign st_b.tx_bit = tx_bit_b;
  assign st_b.ir_en = modem_control_reg_b[IR_EN_BIT];

  // Per-channel pin stages.
  chan_pin_stage u_pins_a (
    .ref_clk(ref_clk),
    .reset(reset),
    .st(st_a),
    .irq_out(irq_channel_a),
    .tx_ready_n(tx_ready_a_n),
    .serial_out(serial_out_a)
  );
  chan_pin_stage u_pins_b (
    .ref_clk(ref_clk),
    .reset(reset),
    .st(st_b),
    .irq_out(irq_channel_b),
    .tx_ready_n(tx_ready_b_n),
    .serial_out(serial_out_b)
  );

  read_start_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == ST_IDLE && !cs_n && rd_fall) |=> (rd_a ^ rd_b) ##1 !(rd_a || rd_b))
    else $error("read strobe not issued once");
  read_data_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == ST_READ && rd_a_ff) |=> data_out == $past(rd_data_a))
    else $error("read byte not captured");
  write_commit_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == ST_WRITE && wr_rise) |=> (wr_a || wr_b) && wr_data == $past(hold_ff))
    else $error("write not committed at rising strobe");
  cs_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == ST_IDLE && cs_n) |=> state_ff == ST_IDLE && !rd_a && !rd_b)
    else $error("access taken without chip select");
  chan_route_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == ST_IDLE && !cs_n && rd_fall && !channel_select) |=> rd_b && !rd_a)
    else $error("select low did not pick channel b");
  broadcast_wr_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == ST_WRITE && wr_rise && bcast) |=> wr_a && wr_b)
    else $error("broadcast write missed a channel");
  addr_pick_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == ST_IDLE && !cs_n && rd_fall) |=> reg_addr == $past(addr))
    else $error("register address not taken");
  bus_release_a: assert property (@(posedge ref_clk)
    (cs_n || read_strobe_n) |-> !data_oe)
    else $error("bus driven outside a read");
  bus_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == ST_WRITE) |-> !data_oe)
    else $error("bus driven during write");
endmodule

// File: hw/host_port_pkg.sv
package host_port_pkg;
  // Width of the host data bus and of the register address.
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  // Bit that makes one write reach both channels.
  localparam int BCAST_BIT = 0;
  // Bit that switches a channel's serial pins to infrared coding.
  localparam int IR_EN_BIT = 6;
  // Reset and idle levels of the transmit pin.
  localparam logic STD_IDLE_LVL = 1'b1;
  localparam logic IR_IDLE_LVL = 1'b0;
  // Reset value of the read data register.
  localparam logic [7:0] RD_DATA_RST = 8'h00;
  // Host port sequencing states.
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} port_state_t;
endpackage
